// ### ebrh_pkg.sv
/*
  Package for the external bus ready/hold sequencer: register map, field
  layout, reset values, state codes and the carrier structs.
  Assumes it is compiled before every other file of the block.
*/
// Functional notes
// - ready high at the sample point adds a wait; ready low ends the cycle.
// - multiplexed modes add a mux wait, optionally a tristate wait, after a cycle.
// - gap is two bus clocks muxed with tristate, zero demuxed without it.
// - read data are captured on the edge that raises the strobe.
// - ready is sampled only after the programmed memory cycle waits.
// - the strobe's leading edge follows the programmed command delay.
// - a hold request waits for the running cycle to finish.
// - a released bus leaves chip selects undriven, pulled high externally.
// - only hold going inactive starts the regain, never the reclaim request.
// - hold may drop without any reclaim request; the bus is regained normally.
package ebrh_pkg;
  // --------------------------------------------------------------
  // register map
  // --------------------------------------------------------------
  localparam int          REG_AW      = 8;
  localparam int          REG_DW      = 32;
  localparam logic [7:0]  OFF_CTRL    = 8'h00;
  localparam logic [7:0]  OFF_ADDR    = 8'h04;
  localparam logic [7:0]  OFF_WDATA   = 8'h08;
  localparam logic [7:0]  OFF_CMD     = 8'h0C;
  localparam logic [7:0]  OFF_STATUS  = 8'h10;
  localparam logic [7:0]  OFF_RDATA   = 8'h14;
  // ctrl fields
  localparam int          CTRL_MUX    = 0;
  localparam int          CTRL_TRI    = 1;
  localparam int          CTRL_RWD    = 2;
  localparam int          CTRL_MC_LO  = 3;
  localparam int          CTRL_MC_HI  = 6;
  // cmd fields
  localparam int          CMD_WRITE   = 0;
  localparam int          CMD_CS_LO   = 1;
  localparam int          CMD_CS_HI   = 3;
  // status fields
  localparam int          STAT_BUSY   = 0;
  localparam int          STAT_HELD   = 1;
  // bus widths and reset values
  localparam int          BUS_AW      = 24;
  localparam int          BUS_DW      = 16;
  localparam int          NUM_CS      = 5;
  localparam logic [3:0]  MC_RESET    = 4'h0;
  localparam logic [23:0] ADDR_RESET  = 24'h000000;
  localparam logic [15:0] DATA_RESET  = 16'h0000;

  // --------------------------------------------------------------
  // types
  // --------------------------------------------------------------
  typedef struct packed {
    logic [3:0] memoryCycleWaitStates;
    logic       rwDelay;
    logic       tristateWaitState;
    logic       muxMode;
  } ebrh_cfg_t;

  typedef struct packed {
    logic        isWrite;
    logic [2:0]  csSel;
    logic [23:0] addr;
    logic [15:0] wdata;
  } ebrh_cmd_t;

  typedef enum logic [7:0] {
    S_IDLE   = 8'h01,
    S_DELAY  = 8'h02,
    S_MCWAIT = 8'h04,
    S_READY  = 8'h08,
    S_MUX    = 8'h10,
    S_TRI    = 8'h20,
    S_HELD   = 8'h40,
    S_REGAIN = 8'h80
  } ebrh_state_t;
endpackage

// ### ebrh_sync2.sv
/*
  Two-flop level synchroniser, one per bit.
  Assumes the inputs are levels that stay put for at least two
  destination clock edges.
*/
`timescale 1ns/10ps
module ebrh_sync2 #(
  parameter int W        = 1,
  parameter bit RST_VAL  = 1'b0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] meta_q;

  // --------------------------------------------------------------
  // first flop feeds only the second flop
  // --------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q  <= {W{RST_VAL}};
      syncOut <= {W{RST_VAL}};
    end else begin
      meta_q  <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule

// ### ebrh_bus_ctrl.sv
/*
  External bus sequencer with ready wait states, mux/tristate waits and
  the hold/acknowledge hand-over to another master.
  Assumes ref_clk (register side) and busClk (bus side) are unrelated;
  one bus clock output period is two busClk periods.
*/
`timescale 1ns/10ps
module ebrh_bus_ctrl #(
  parameter int NCS = ebrh_pkg::NUM_CS
) (
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  input  wire logic [ebrh_pkg::REG_AW-1:0] regAddr,
  input  wire logic [ebrh_pkg::REG_DW-1:0] regWdata,
  input  wire logic                        regWr,
  input  wire logic                        regRd,
  output logic      [ebrh_pkg::REG_DW-1:0] regRdata,
  input  wire logic                        busClk,
  output logic                             busClockOut,
  input  wire logic                        readyN,
  input  wire logic                        holdReqN,
  output logic                             busGrantAckN,
  output logic                             busReclaimRequestN,
  output logic      [NCS-1:0]              chipSelectLinesOut,
  output logic      [NCS-1:0]              chipSelectLinesOe,
  output logic      [ebrh_pkg::BUS_AW-1:0] addrOut,
  output logic                             aleOut,
  output logic                             rdNOut,
  output logic                             wrNOut,
  output logic                             ctlOe,
  input  wire logic [ebrh_pkg::BUS_DW-1:0] dataIn,
  output logic      [ebrh_pkg::BUS_DW-1:0] dataOut,
  output logic                             dataOe
);
  import ebrh_pkg::*;

  // --------------------------------------------------------------
  // register side (ref_clk)
  // --------------------------------------------------------------
  ebrh_cfg_t               cfg_q;
  ebrh_cmd_t               cmd_q;
  logic                    busy_q;
  logic                    reqTgl_q;
  logic                    doneSeen_q;
  logic [BUS_DW-1:0]       rdLatch_q;
  logic                    doneSync;
  logic                    heldSync;
  logic                    doneEvt;
  logic                    doneTgl_q;
  logic [BUS_DW-1:0]       capData_q;
  logic                    heldFlag_q;

  assign doneEvt = doneSync ^ doneSeen_q;

  ebrh_sync2 #(.W(2), .RST_VAL(1'b0)) uSyncRef (
    .clk     (ref_clk),
    .rst     (rst),
    .asyncIn ({doneTgl_q, heldFlag_q}),
    .syncOut ({doneSync, heldSync})
  );

  // config and command registers; frozen while a cycle is in flight
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg_q <= '{memoryCycleWaitStates: MC_RESET, default: 1'b0};
      cmd_q <= '{addr: ADDR_RESET, wdata: DATA_RESET, csSel: 3'h0, isWrite: 1'b0};
    end else if (regWr && !busy_q) begin
      unique case (regAddr)
        OFF_CTRL: begin
          cfg_q.muxMode               <= regWdata[CTRL_MUX];
          cfg_q.tristateWaitState     <= regWdata[CTRL_TRI];
          cfg_q.rwDelay               <= regWdata[CTRL_RWD];
          cfg_q.memoryCycleWaitStates <= regWdata[CTRL_MC_HI:CTRL_MC_LO];
        end
        OFF_ADDR:  cmd_q.addr  <= regWdata[BUS_AW-1:0];
        OFF_WDATA: cmd_q.wdata <= regWdata[BUS_DW-1:0];
        OFF_CMD: begin
          cmd_q.isWrite <= regWdata[CMD_WRITE];
          cmd_q.csSel   <= regWdata[CMD_CS_HI:CMD_CS_LO];
        end
        default: ;
      endcase
    end
  end

  // start toggle out, done toggle back; busy covers the whole round trip
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busy_q     <= 1'b0;
      reqTgl_q   <= 1'b0;
      doneSeen_q <= 1'b0;
      rdLatch_q  <= DATA_RESET;
    end else begin
      doneSeen_q <= doneSync;
      if (doneEvt) begin
        busy_q    <= 1'b0;
        rdLatch_q <= capData_q;  // stable: link side holds it until next start
      end else if (regWr && !busy_q && regAddr == OFF_CMD) begin
        busy_q   <= 1'b1;
        reqTgl_q <= ~reqTgl_q;
      end
    end
  end

  // read port, data in the cycle after the strobe only
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      regRdata <= '0;
    end else begin
      regRdata <= '0;
      if (regRd) begin
        unique case (regAddr)
          OFF_CTRL:   regRdata <= REG_DW'({cfg_q.memoryCycleWaitStates, cfg_q.rwDelay,
                                           cfg_q.tristateWaitState, cfg_q.muxMode});
          OFF_ADDR:   regRdata <= REG_DW'(cmd_q.addr);
          OFF_WDATA:  regRdata <= REG_DW'(cmd_q.wdata);
          OFF_CMD:    regRdata <= REG_DW'({cmd_q.csSel, cmd_q.isWrite});
          OFF_STATUS: regRdata <= REG_DW'({heldSync, busy_q});
          OFF_RDATA:  regRdata <= REG_DW'(rdLatch_q);
          default:    regRdata <= '0;
        endcase
      end
    end
  end

  // --------------------------------------------------------------
  // bus side (busClk)
  // --------------------------------------------------------------
  ebrh_state_t       state_q;
  logic              phase_q;
  logic              reqSync;
  logic              reqSeen_q;
  logic              pend_q;
  logic              readySyncN;
  logic              holdSyncN;
  logic [3:0]        mcCnt_q;
  ebrh_cfg_t         lcfg_q;
  logic              lWrite_q;
  logic [2:0]        lCs_q;
  logic              step;
  logic              startNow;

  // step marks the busClk edge that ends one bus clock output period
  assign step     = phase_q;
  assign startNow = step && state_q == S_IDLE && holdSyncN && pend_q;

  ebrh_sync2 #(.W(1), .RST_VAL(1'b0)) uSyncReq (
    .clk     (busClk),
    .rst     (rst),
    .asyncIn (reqTgl_q),
    .syncOut (reqSync)
  );

  // ready and hold are pins, so both pass two flops before use
  ebrh_sync2 #(.W(2), .RST_VAL(1'b1)) uSyncPins (
    .clk     (busClk),
    .rst     (rst),
    .asyncIn ({readyN, holdReqN}),
    .syncOut ({readySyncN, holdSyncN})
  );

  // bus clock output: divide busClk by two
  always_ff @(posedge busClk or posedge rst) begin
    if (rst) begin
      phase_q     <= 1'b0;
      busClockOut <= 1'b0;
    end else begin
      phase_q     <= ~phase_q;
      busClockOut <= ~phase_q;
    end
  end

  // pending start request from the register side
  always_ff @(posedge busClk or posedge rst) begin
    if (rst) begin
      reqSeen_q <= 1'b0;
      pend_q    <= 1'b0;
    end else begin
      reqSeen_q <= reqSync;
      if (reqSync ^ reqSeen_q)
        pend_q <= 1'b1;
      else if (startNow)
        pend_q <= 1'b0;
    end
  end

  // sequencer state
  always_ff @(posedge busClk or posedge rst) begin
    if (rst) begin
      state_q <= S_IDLE;
      mcCnt_q <= MC_RESET;
      lcfg_q  <= '{memoryCycleWaitStates: MC_RESET, default: 1'b0};
      lWrite_q <= 1'b0;
      lCs_q    <= 3'h0;
    end else if (step) begin
      unique case (state_q)
        S_IDLE: begin
          if (!holdSyncN) begin
            state_q <= S_HELD;
          end else if (pend_q) begin
            lcfg_q   <= cfg_q;
            lWrite_q <= cmd_q.isWrite;
            lCs_q    <= cmd_q.csSel;
            mcCnt_q  <= cfg_q.memoryCycleWaitStates;
            if (cfg_q.rwDelay)
              state_q <= S_DELAY;
            else if (cfg_q.memoryCycleWaitStates != MC_RESET)
              state_q <= S_MCWAIT;
            else
              state_q <= S_READY;
          end
        end
        S_DELAY: begin
          state_q <= (mcCnt_q != MC_RESET) ? S_MCWAIT : S_READY;
        end
        S_MCWAIT: begin
          mcCnt_q <= mcCnt_q - 4'h1;
          if (mcCnt_q == 4'h1)
            state_q <= S_READY;
        end
        S_READY: begin
          if (!readySyncN) begin
            if (lcfg_q.muxMode)
              state_q <= S_MUX;
            else if (lcfg_q.tristateWaitState)
              state_q <= S_TRI;
            else
              state_q <= S_IDLE;
          end
        end
        S_MUX: state_q <= lcfg_q.tristateWaitState ? S_TRI : S_IDLE;
        S_TRI: state_q <= S_IDLE;
        S_HELD: begin
          if (holdSyncN)
            state_q <= S_REGAIN;
        end
        S_REGAIN: state_q <= S_IDLE;
      endcase
    end
  end

  // command strobes, address latch enable, chip select and data drive
  always_ff @(posedge busClk or posedge rst) begin
    if (rst) begin
      aleOut             <= 1'b0;
      rdNOut             <= 1'b1;
      wrNOut             <= 1'b1;
      addrOut            <= ADDR_RESET;
      dataOut            <= DATA_RESET;
      dataOe             <= 1'b0;
      chipSelectLinesOut <= '1;
      doneTgl_q          <= 1'b0;
      capData_q          <= DATA_RESET;
    end else if (step) begin
      aleOut <= 1'b0;
      if (startNow) begin
        aleOut                       <= 1'b1;
        addrOut                      <= cmd_q.addr;
        dataOut                      <= cmd_q.wdata;
        dataOe                       <= cmd_q.isWrite;
        chipSelectLinesOut           <= '1;
        chipSelectLinesOut[cmd_q.csSel] <= 1'b0;
        if (!cfg_q.rwDelay) begin
          rdNOut <= cmd_q.isWrite;
          wrNOut <= ~cmd_q.isWrite;
        end
      end else if (state_q == S_DELAY) begin
        rdNOut <= lWrite_q;  // delayed leading edge
        wrNOut <= ~lWrite_q;
      end else if (state_q == S_READY && !readySyncN) begin
        rdNOut             <= 1'b1;
        wrNOut             <= 1'b1;
        dataOe             <= 1'b0;
        chipSelectLinesOut <= '1;
        doneTgl_q          <= ~doneTgl_q;
        if (!lWrite_q)
          capData_q <= dataIn;
      end
    end
  end

  // arbitration outputs and drive enables, moved only on bus clock steps
  always_ff @(posedge busClk or posedge rst) begin
    if (rst) begin
      busGrantAckN       <= 1'b1;
      busReclaimRequestN <= 1'b1;
      chipSelectLinesOe  <= '1;
      ctlOe              <= 1'b1;
      heldFlag_q         <= 1'b0;
    end else if (step) begin
      if (state_q == S_IDLE && !holdSyncN) begin
        busGrantAckN      <= 1'b0;
        chipSelectLinesOe <= '0;
        ctlOe             <= 1'b0;
        heldFlag_q        <= 1'b1;
      end else if (state_q == S_HELD) begin
        // reclaim is a hint only; regain waits for hold to go inactive
        busReclaimRequestN <= ~(pend_q && !holdSyncN);
        if (holdSyncN)
          busGrantAckN <= 1'b1;
      end else if (state_q == S_REGAIN) begin
        busReclaimRequestN <= 1'b1;
        chipSelectLinesOe  <= '1;
        ctlOe              <= 1'b1;
        heldFlag_q         <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------
  // checks on the bus side
  // --------------------------------------------------------------
  default clocking cbBus @(posedge busClk); endclocking
  default disable iff (rst);

  a_ready_ends_cycle: assert property (
    (step && state_q == S_READY && !readySyncN) |=> (rdNOut && wrNOut && state_q != S_READY))
    else $error("ready low did not end the cycle");
  a_ready_wait_holds: assert property (
    (step && state_q == S_READY && readySyncN) |=> state_q == S_READY)
    else $error("ready high did not add a wait state");
  a_mux_wait_added: assert property (
    (step && state_q == S_READY && !readySyncN && lcfg_q.muxMode) |=> state_q == S_MUX)
    else $error("mux wait state missing");
  a_demux_zero_gap: assert property (
    (step && state_q == S_READY && !readySyncN && !lcfg_q.muxMode
     && !lcfg_q.tristateWaitState) |=> state_q == S_IDLE)
    else $error("demux cycle did not return to idle at once");
  a_tri_wait_added: assert property (
    (step && state_q == S_READY && !readySyncN && !lcfg_q.muxMode
     && lcfg_q.tristateWaitState) |=> state_q == S_TRI)
    else $error("tristate wait state missing after demux cycle");
  a_mux_tri_gap: assert property (
    (step && state_q == S_MUX && lcfg_q.tristateWaitState) |=> state_q == S_TRI)
    else $error("mux cycle with tristate wait lacks second gap step");
  a_read_capture: assert property (
    (step && state_q == S_READY && !readySyncN && !lWrite_q)
    |=> (capData_q == $past(dataIn) && rdNOut))
    else $error("read data not taken at strobe rise");
  a_mc_before_ready: assert property (
    (step && state_q == S_IDLE && startNow && !cfg_q.rwDelay
     && cfg_q.memoryCycleWaitStates != MC_RESET) |=> state_q == S_MCWAIT)
    else $error("ready sampled before memory cycle waits");
  a_delay_strobe: assert property (
    (startNow && cfg_q.rwDelay) |=> (rdNOut && wrNOut) ##2 (!rdNOut || !wrNOut))
    else $error("delayed command edge wrong");
  a_hold_after_cycle: assert property (
    $fell(busGrantAckN) |-> $past(state_q) == S_IDLE)
    else $error("bus granted during a cycle");
  a_cs_released: assert property (
    !busGrantAckN |-> (chipSelectLinesOe == '0 && !ctlOe))
    else $error("chip selects driven while released");
  a_regain_by_hold: assert property (
    (state_q == S_HELD && !holdSyncN) |=> state_q == S_HELD)
    else $error("regain started while hold still active");
  a_redrive_first: assert property (
    (state_q == S_REGAIN && step) |=> (ctlOe && chipSelectLinesOe == '1))
    else $error("bus not driven again after regain");

  c_read_cycle:  cover property (step && state_q == S_READY && !readySyncN && !lWrite_q);
  c_wait_state:  cover property (step && state_q == S_READY && readySyncN);
  c_tri_gap:     cover property (state_q == S_MUX ##[1:4] state_q == S_TRI);
  c_hold_regain: cover property (state_q == S_HELD ##[1:200] state_q == S_REGAIN);
endmodule

// ### ebrh_ext_partner.sv
/*
  Far-side model: one external memory of 16 words answering on any chip
  select, with ready wait states, plus an alternate master asking for the bus.
  Assumes the sequencer's outputs and the bench's wait count and bus request.
*/
`timescale 1ns/10ps
module ebrh_ext_partner (
  input  wire logic                        busClk,
  input  wire logic [ebrh_pkg::NUM_CS-1:0] csOut,
  input  wire logic [ebrh_pkg::NUM_CS-1:0] csOe,
  input  wire logic                        ctlOe,
  input  wire logic                        rdN,
  input  wire logic                        wrN,
  input  wire logic [ebrh_pkg::BUS_AW-1:0] addr,
  input  wire logic [ebrh_pkg::BUS_DW-1:0] wdata,
  input  wire logic                        dataOe,
  input  wire logic [7:0]                  waitCycles,
  input  wire logic                        wantBus,
  output logic                             readyN,
  output logic                             holdReqN,
  output logic      [ebrh_pkg::BUS_DW-1:0] dataIn
);
  import ebrh_pkg::*;
  logic [BUS_DW-1:0] memArr [16];
  logic [NUM_CS-1:0] csWire;
  logic [7:0]        strobeCnt;
  logic [1:0]        lowCnt = 2'h3;
  logic              readyQ = 1'b1;
  logic [BUS_DW-1:0] staleQ = 16'h5A5A;
  logic              cmdActive;

  // ----------------------------------------------------------------
  // pins as seen on the board
  // ----------------------------------------------------------------
  // released chip selects float up through the pull-ups
  assign csWire    = csOut | ~csOe;
  assign cmdActive = ctlOe && !(&csWire) && !(rdN && wrN);
  assign readyN    = readyQ;
  assign holdReqN  = !wantBus;
  // undriven data lines show the inverse of the word one busClk before, so late capture shows
  assign dataIn    = (ctlOe && !rdN && !(&csWire)) ? memArr[addr[3:0]] : staleQ;

  // ----------------------------------------------------------------
  // responder timing
  // ----------------------------------------------------------------
  // count busClk edges since the strobe fell
  always_ff @(posedge busClk) begin
    if (!cmdActive) strobeCnt <= 8'h00;
    else if (strobeCnt != 8'hFF) strobeCnt <= strobeCnt + 8'h01;
  end
  // ready drops after the wait count, stays low past the strobe end
  always_ff @(posedge busClk) begin
    if (cmdActive && strobeCnt >= waitCycles) begin
      readyQ <= 1'b0;
      lowCnt <= 2'h0;
    end else if (lowCnt != 2'h3) lowCnt <= lowCnt + 2'h1;
    else readyQ <= 1'b1;
  end
  // inverse pattern on an idle data bus
  always_ff @(posedge busClk) staleQ <= ~dataIn;
  // write data taken while the strobe is low; last edge before its end wins
  always @(posedge busClk) begin
    if (ctlOe && !wrN && !(&csWire)) memArr[addr[3:0]] <= dataOe ? wdata : ~wdata;
  end
endmodule

// ### tb_ext_bus_ready_hold_control.sv
/*
  Self-checking bench for the bus sequencer: register access, bus cycles in
  several modes, and the hold hand-over with and without a reclaim request.
  Assumes the partner model in ebrh_ext_partner.sv.
*/
`timescale 1ns/10ps
module tb_ext_bus_ready_hold_control;
  import ebrh_pkg::*;
  logic              ref_clk, rst, busClk, regWr, regRd, wantBus;
  logic [REG_AW-1:0] regAddr;
  logic [REG_DW-1:0] regWdata, regRdata, rd;
  logic [7:0]        waitCycles;
  logic              busClockOut, readyN, holdReqN, busGrantAckN, busReclaimRequestN;
  logic [NUM_CS-1:0] chipSelectLinesOut, chipSelectLinesOe;
  logic [BUS_AW-1:0] addrOut;
  logic              aleOut, rdNOut, wrNOut, ctlOe, dataOe, prevAle;
  logic [BUS_DW-1:0] dataIn, dataOut;
  logic [1:0]        aleSnap;
  logic [6:0]        ctrlTab [7] = '{7'h00, 7'h01, 7'h03, 7'h04, 7'h18, 7'h1D, 7'h02};
  logic [7:0]        waitTab [7] = '{8'h00, 8'h0C, 8'h00, 8'h05, 8'h00, 8'h0C, 8'h00};
  int                badCount, totalChecks, cycleCount, lowRun, lastLow, lowMin;

  ebrh_bus_ctrl dut_u (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .busClk(busClk),
    .busClockOut(busClockOut), .readyN(readyN), .holdReqN(holdReqN),
    .busGrantAckN(busGrantAckN), .busReclaimRequestN(busReclaimRequestN),
    .chipSelectLinesOut(chipSelectLinesOut), .chipSelectLinesOe(chipSelectLinesOe),
    .addrOut(addrOut), .aleOut(aleOut), .rdNOut(rdNOut), .wrNOut(wrNOut), .ctlOe(ctlOe),
    .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe));
  ebrh_ext_partner partner_u (.busClk(busClk), .csOut(chipSelectLinesOut),
    .csOe(chipSelectLinesOe), .ctlOe(ctlOe), .rdN(rdNOut), .wrN(wrNOut), .addr(addrOut),
    .wdata(dataOut), .dataOe(dataOe), .waitCycles(waitCycles), .wantBus(wantBus),
    .readyN(readyN), .holdReqN(holdReqN), .dataIn(dataIn));

  // ----------------------------------------------------------------
  // clocks and watchdog
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // link clock offset so its edges never line up with ref_clk
  initial begin
    busClk = 1'b0;
    #7;
    forever #16 busClk = ~busClk;
  end
  always @(posedge ref_clk) begin
    cycleCount++;
    if (cycleCount == 20000) begin
      badCount++;
      reportAndStop();
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      badCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge ref_clk);
    regWr    <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe
  task automatic regRead(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge ref_clk);
    regRd   <= 1'b0;
    #1 d = regRdata;
  endtask
  task automatic waitIdle();
    logic [31:0] s;
    for (int k = 0; k < 60; k++) begin
      regRead(OFF_STATUS, s);
      if (s[STAT_BUSY] === 1'b0) break;
    end
    chk({31'h0, s[STAT_BUSY]}, 32'h0);
  endtask
  task automatic waitGrant(input logic want);
    for (int k = 0; k < 100 && busGrantAckN !== want; k++) @(posedge ref_clk);
    chk({31'h0, busGrantAckN}, {31'h0, want});
  endtask
  // one external cycle; read data returned through r
  task automatic busOp(input logic w, input logic [2:0] cs, input logic [3:0] a,
                       input logic [15:0] d, output logic [31:0] r);
    regWrite(OFF_ADDR, {28'h0, a});
    regWrite(OFF_WDATA, {16'h0, d});
    regWrite(OFF_CMD, {28'h0, cs, w});
    waitIdle();
    if (!w) regRead(OFF_RDATA, r);
  endtask
  task automatic reportAndStop();
    if (badCount == 0 && totalChecks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // bus-side monitor: strobe placement, strobe length, released bus
  // ----------------------------------------------------------------
  always @(posedge busClk) begin
    #1;
    if (aleOut === 1'b1 && prevAle !== 1'b1) begin
      aleSnap = {rdNOut, wrNOut};
      chk({26'h0, ctlOe, chipSelectLinesOe}, 32'h3F);
    end
    prevAle = aleOut;
    if (rdNOut === 1'b0 || wrNOut === 1'b0) lowRun++;
    else if (lowRun != 0) begin
      lastLow = lowRun;
      lowRun  = 0;
    end
    // a granted bus carries no cycle and nothing driven
    if (busGrantAckN === 1'b0) chk({aleOut, rdNOut, wrNOut, ctlOe, chipSelectLinesOe},
                                   9'h0C0);
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWdata = 32'h0;
    wantBus = 1'b0;
    waitCycles = 8'h00;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    // reset values and an unmapped place
    regRead(OFF_CTRL, rd);
    chk(rd, 32'h0);
    regRead(OFF_STATUS, rd);
    chk(rd, 32'h0);
    regRead(8'h20, rd);
    chk(rd, 32'h0);
    chk({busGrantAckN, busReclaimRequestN}, 32'h3);
    // seven mode settings: write then read back through the memory
    // last entry is a demultiplexed bus with the tristate wait after it
    for (int i = 0; i < 7; i++) begin
      waitCycles <= waitTab[i];
      regWrite(OFF_CTRL, {25'h0, ctrlTab[i]});
      regRead(OFF_CTRL, rd);
      chk(rd, {25'h0, ctrlTab[i]});
      lowMin = ctrlTab[i][CTRL_RWD] ? 2 * ctrlTab[i][6:3] : 2 * ctrlTab[i][6:3] + 2;
      if (waitTab[i] + 2 > lowMin) lowMin = waitTab[i] + 2;
      busOp(1'b1, 3'(i % 5), 4'(i), 16'h3C00 + 16'(i), rd);
      chk({16'h0, partner_u.memArr[i]}, 32'h3C00 + i);
      chk({30'h0, aleSnap}, ctrlTab[i][CTRL_RWD] ? 32'h3 : 32'h2);
      chk(32'(lastLow >= lowMin), 32'h1);
      busOp(1'b0, 3'(i % 5), 4'(i), 16'h0, rd);
      chk(rd, 32'h3C00 + i);
      chk({30'h0, aleSnap}, ctrlTab[i][CTRL_RWD] ? 32'h3 : 32'h1);
      chk(32'(lastLow >= lowMin), 32'h1);
    end
    // hold arrives during a slow write: the write completes first
    waitCycles <= 8'h0C;
    regWrite(OFF_CTRL, 32'h0);
    regWrite(OFF_ADDR, 32'h7);
    regWrite(OFF_WDATA, 32'h5AA5);
    regWrite(OFF_CMD, 32'h1);
    // ask for the bus only once the write strobe is out, else hold wins in idle
    wait (wrNOut === 1'b0);
    @(posedge ref_clk);
    wantBus <= 1'b1;
    waitGrant(1'b0);
    chk({16'h0, partner_u.memArr[7]}, 32'h5AA5);
    chk({30'h0, ctlOe, dataOe}, 32'h0);
    chk({27'h0, chipSelectLinesOe}, 32'h0);
    waitIdle();
    regRead(OFF_STATUS, rd);
    chk({31'h0, rd[STAT_HELD]}, 32'h1);
    // a start while held raises reclaim but does not take the bus back
    // busy is clear while held, so the start is accepted and waits in pend_q until the bus is regained
    regWrite(OFF_ADDR, 32'h9);
    regWrite(OFF_WDATA, 32'hC3A5);
    regWrite(OFF_CMD, 32'h3);
    repeat (20) @(posedge ref_clk);
    chk({busReclaimRequestN, busGrantAckN}, 32'h0);
    wantBus <= 1'b0;
    waitGrant(1'b1);
    waitIdle();
    chk({16'h0, partner_u.memArr[9]}, 32'hC3A5);
    chk({31'h0, busReclaimRequestN}, 32'h1);
    // hold dropped with no reclaim pending
    wantBus <= 1'b1;
    waitGrant(1'b0);
    wantBus <= 1'b0;
    waitGrant(1'b1);
    busOp(1'b0, 3'h1, 4'h9, 16'h0, rd);
    chk(rd, 32'hC3A5);
    reportAndStop();
  end
endmodule
